/* hdl/titl_pkg.sv */
// Shared constants and types of the tracker discrete I/O block
package titl_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int HOLD_TIME_MS = 3000;
   localparam int HOLD_CYCLES = HOLD_TIME_MS * (CLK_HZ / 1000);

   localparam int BAUD_4800 = 4800;
   localparam int BAUD_9600 = 9600;
   localparam int BAUD_19200 = 19200;
   localparam int BAUD_38400 = 38400;
   localparam int BAUD_57600 = 57600;
   localparam int BAUD_115200 = 115200;
   localparam int DIV_W = 15;

   typedef enum logic [2:0] {
      titl_b4800 = 3'b000,
      titl_b9600 = 3'b001,
      titl_b19200 = 3'b010,
      titl_b38400 = 3'b011,
      titl_b57600 = 3'b100,
      titl_b115200 = 3'b101
   } titl_baud_type;

   typedef enum logic [1:0] {
      titl_in_general = 2'b00,
      titl_in_emergency = 2'b01,
      titl_in_test = 2'b10
   } titl_in_kind_type;

   typedef enum logic [1:0] {
      titl_em_idle = 2'b00,
      titl_em_entered = 2'b01,
      titl_em_armed = 2'b10
   } titl_em_state_type;

   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_INCFG = 8'h04;
   localparam logic [7:0] REG_OUT = 8'h08;
   localparam logic [7:0] REG_BAUD = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_EVENT = 8'h14;

   localparam int CTRL_LATCH_BIT = 0;
   localparam int CTRL_REPORT_BIT = 1;
   localparam int CTRL_TEST_EXIT_BIT = 2;
   localparam int CFG_KIND_LSB = 0;
   localparam int CFG_RISE_BIT = 2;
   localparam int CFG_FALL_BIT = 3;
   localparam int CFG_W = 4;
   localparam int EVENT_REPORT_BIT = 0;

   localparam logic [15:0] INCFG_RESET = 16'h88A9;
   localparam logic [2:0] OUT_RESET = 3'h0;
   localparam logic [3:0] NOTICE_TAG = 4'hA;
endpackage

/* hdl/titl_if.sv */
// Carrier between the synchroniser, serial transmitter and core
`timescale 1ns/10ps
`default_nettype none
interface titl_if;
   logic [3:0] level;
   logic [3:0] rise;
   logic [3:0] fall;
   logic button;
   logic tx_start;
   logic [7:0] tx_byte;
   logic [2:0] baud_sel;
   logic tx_busy;
   logic txd;
   modport sync_end (output level, rise, fall, button);
   modport tx_end (input tx_start, tx_byte, baud_sel, output tx_busy, txd);
   modport core (input level, rise, fall, button, tx_busy, txd,
                 output tx_start, tx_byte, baud_sel);
endinterface
`default_nettype wire

/* hdl/titl_sync.sv */
// Pin synchroniser and edge detector for the four inputs and the button
`timescale 1ns/10ps
`default_nettype none
module titl_sync
   import titl_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [3:0] ext_in,
   input wire logic button_n,
   titl_if.sync_end io
);
   typedef struct packed {
      logic [4:0] meta;
      logic [4:0] sync;
      logic [3:0] prev;
      logic [3:0] rise;
      logic [3:0] fall;
   } titl_sync_state_type;

   titl_sync_state_type r;
   titl_sync_state_type next_r;
   logic [3:0] merged;

   always_comb begin
      next_r = r;
      next_r.meta = {button_n, ext_in};
      next_r.sync = r.meta;
      // Button pulls the shared first input low
      merged = {r.sync[3:1], r.sync[0] & r.sync[4]};
      next_r.prev = merged;
      next_r.rise = merged & ~r.prev;
      next_r.fall = ~merged & r.prev;
   end

   // Idle high after reset, as the pull-ups hold open pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '{meta: 5'h1F, sync: 5'h1F, prev: 4'hF, rise: 4'h0,
                fall: 4'h0};
      end else begin
         r <= next_r;
      end
   end

   assign io.level = r.prev;
   assign io.rise = r.rise;
   assign io.fall = r.fall;
   assign io.button = r.sync[4];
endmodule
`default_nettype wire

/* hdl/titl_uart_tx.sv */
// Host serial transmitter with programmable baud divider
`timescale 1ns/10ps
`default_nettype none
module titl_uart_tx
   import titl_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   titl_if.tx_end io
);
   typedef struct packed {
      logic [DIV_W-1:0] div;
      logic [8:0] shreg;
      logic [3:0] bits;
      logic busy;
      logic txd;
   } titl_tx_state_type;

   titl_tx_state_type r;
   titl_tx_state_type next_r;
   logic [DIV_W-1:0] divisor;

   always_comb begin
      next_r = r;
      case (io.baud_sel)
         titl_b4800: divisor = DIV_W'(CLK_HZ / BAUD_4800 - 1);
         titl_b9600: divisor = DIV_W'(CLK_HZ / BAUD_9600 - 1);
         titl_b38400: divisor = DIV_W'(CLK_HZ / BAUD_38400 - 1);
         titl_b57600: divisor = DIV_W'(CLK_HZ / BAUD_57600 - 1);
         titl_b115200: divisor = DIV_W'(CLK_HZ / BAUD_115200 - 1);
         default: divisor = DIV_W'(CLK_HZ / BAUD_19200 - 1);
      endcase
      if (!r.busy) begin
         if (io.tx_start) begin
            next_r.busy = 1'b1;
            next_r.txd = 1'b0;
            next_r.shreg = {1'b1, io.tx_byte};
            next_r.bits = 4'h9;
            next_r.div = divisor;
         end
      end else if (r.div == '0) begin
         next_r.div = divisor;
         if (r.bits == 4'h0) begin
            next_r.busy = 1'b0;
         end else begin
            next_r.txd = r.shreg[0];
            next_r.shreg = {1'b1, r.shreg[8:1]};
            next_r.bits = r.bits - 4'h1;
         end
      end else begin
         next_r.div = r.div - DIV_W'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '{div: '0, shreg: 9'h1FF, bits: 4'h0, busy: 1'b0,
                txd: 1'b1};
      end else begin
         r <= next_r;
      end
   end

   assign io.tx_busy = r.busy;
   assign io.txd = r.txd;
endmodule
`default_nettype wire

/* hdl/tracker_io_trigger_logic.sv */
// Tracker discrete inputs, emergency logic, outputs and APB registers
//
// Notes on behaviour
// - Four discrete inputs, three discrete outputs.
// - Inputs pulled up; open pin reads high.
// - Each input: emergency/test/general, rise/fall/both trigger.
// - Emergency input trigger enters emergency tracking.
// - Test input trigger enters test tracking.
// - General input trigger queues an input report.
// - Position reports carry every current input value.
// - Defaults: input zero emergency, one test, falling.
// - Button shares input zero for emergency.
// - Momentary: short button press enters emergency.
// - Momentary: hold over three seconds leaves emergency.
// - Emergency indicator lit while emergency active.
// - Switch type momentary or latching, momentary default.
// - Latching: emergency only while trigger condition holds.
// - Report enabled: pin change sends value notice.
// - Outputs set by command or remote update.
// - Fixed baud, default 19.2k, programmable 4.8k-115.2k.
`timescale 1ns/10ps
`default_nettype none
module tracker_io_trigger_logic
   import titl_pkg::*;
#(
   parameter int unsigned HOLD_COUNT = HOLD_CYCLES,
   parameter int HOLD_W = 29
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] ext_in,
   input wire logic button_n,
   input wire logic remote_out_valid,
   input wire logic [2:0] remote_out_data,
   output logic [2:0] out_pins,
   output logic emergency_led,
   output logic emergency_mode,
   output logic test_mode,
   output logic input_report_req,
   output logic [3:0] input_values,
   output logic serial_tx
);
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic latching;
      logic report_en;
      logic [15:0] incfg;
      logic [2:0] outs;
      logic [2:0] baud;
      titl_em_state_type em_state;
      logic [HOLD_W-1:0] hold;
      logic led;
      logic em_mode;
      logic test;
      logic report_req;
      logic report_pending;
      logic notice_pending;
      logic tx_start;
      logic [7:0] tx_byte;
      logic [3:0] values;
      logic [3:0] last_values;
   } titl_core_state_type;

   titl_if bus ();

   titl_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .ext_in(ext_in),
      .button_n(button_n),
      .io(bus.sync_end)
   );

   titl_uart_tx u_tx (
      .pclk(pclk),
      .presetn(presetn),
      .io(bus.tx_end)
   );

   titl_core_state_type r;
   titl_core_state_type next_r;

   logic [3:0] trig_ev;
   logic [3:0] trig_level;
   logic [3:0] is_em;
   logic [3:0] is_test;
   logic [3:0] is_gen;
   logic em_trig;
   logic em_cond;
   logic test_trig;
   logic gen_trig;
   logic access;
   logic wr;
   logic rd_ok;
   logic [31:0] rd_val;

   // Per input decode of kind, trigger edge and level condition
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_in
         logic [CFG_W-1:0] cfg;
         assign cfg = r.incfg[gi*CFG_W +: CFG_W];
         assign is_em[gi] = (cfg[CFG_KIND_LSB +: 2] == titl_in_emergency);
         assign is_test[gi] = (cfg[CFG_KIND_LSB +: 2] == titl_in_test);
         assign is_gen[gi] = (cfg[CFG_KIND_LSB +: 2] == titl_in_general);
         assign trig_ev[gi] = (cfg[CFG_RISE_BIT] & bus.rise[gi])
            | (cfg[CFG_FALL_BIT] & bus.fall[gi]);
         // A both-edges trigger counts as active while low
         assign trig_level[gi] = cfg[CFG_FALL_BIT] ? ~bus.level[gi]
            : (cfg[CFG_RISE_BIT] & bus.level[gi]);
      end
   endgenerate

   assign em_trig = |(trig_ev & is_em);
   assign em_cond = |(trig_level & is_em);
   assign test_trig = |(trig_ev & is_test);
   assign gen_trig = |(trig_ev & is_gen);

   assign access = psel & penable;
   assign wr = access & r.pready & pwrite;

   // Read decode; unmapped addresses answer with an error
   always_comb begin
      rd_val = 32'h0;
      rd_ok = 1'b1;
      if (paddr == REG_CTRL) begin
         rd_val[CTRL_LATCH_BIT] = r.latching;
         rd_val[CTRL_REPORT_BIT] = r.report_en;
      end else if (paddr == REG_INCFG) begin
         rd_val[15:0] = r.incfg;
      end else if (paddr == REG_OUT) begin
         rd_val[2:0] = r.outs;
      end else if (paddr == REG_BAUD) begin
         rd_val[2:0] = r.baud;
      end else if (paddr == REG_STATUS) begin
         rd_val[3:0] = r.values;
         rd_val[4] = r.em_mode;
         rd_val[5] = r.test;
         rd_val[6] = r.notice_pending;
         rd_val[7] = bus.tx_busy;
      end else if (paddr == REG_EVENT) begin
         rd_val[EVENT_REPORT_BIT] = r.report_pending;
      end else begin
         rd_ok = 1'b0;
      end
   end

   always_comb begin
      next_r = r;
      next_r.report_req = 1'b0;
      next_r.tx_start = 1'b0;

      // One wait state, so prdata and pready both leave flip-flops
      next_r.pready = access & ~r.pready;
      if (access & ~r.pready) begin
         next_r.prdata = pwrite ? 32'h0 : rd_val;
         next_r.pslverr = ~rd_ok;
      end else if (r.pready) begin
         next_r.pslverr = 1'b0;
      end

      // Register writes take effect on the completing edge
      if (wr && rd_ok) begin
         if (paddr == REG_CTRL) begin
            next_r.latching = pwdata[CTRL_LATCH_BIT];
            next_r.report_en = pwdata[CTRL_REPORT_BIT];
            if (pwdata[CTRL_TEST_EXIT_BIT]) begin
               next_r.test = 1'b0;
            end
         end else if (paddr == REG_INCFG) begin
            next_r.incfg = pwdata[15:0];
         end else if (paddr == REG_OUT) begin
            next_r.outs = pwdata[2:0];
         end else if (paddr == REG_BAUD) begin
            // Codes past the table are refused, rate unchanged
            if (pwdata[2:0] <= titl_b115200) begin
               next_r.baud = pwdata[2:0];
            end
         end else if (paddr == REG_EVENT) begin
            if (pwdata[EVENT_REPORT_BIT]) begin
               next_r.report_pending = 1'b0;
            end
         end
      end

      // Remote update lands after a local write in the same cycle
      if (remote_out_valid) begin
         next_r.outs = remote_out_data;
      end

      // Test entry; a new trigger beats a simultaneous exit write
      if (test_trig) begin
         next_r.test = 1'b1;
      end

      // General triggers queue a report, set beats clear
      if (gen_trig) begin
         next_r.report_req = 1'b1;
         next_r.report_pending = 1'b1;
      end

      // Live input values for the position report builder
      next_r.values = bus.level;

      // Emergency tracking state
      case (r.em_state)
         titl_em_idle: begin
            next_r.hold = '0;
            if (r.latching) begin
               if (em_cond) begin
                  next_r.em_state = titl_em_entered;
               end
            end else if (em_trig) begin
               next_r.em_state = titl_em_entered;
            end
         end
         titl_em_entered: begin
            next_r.hold = '0;
            if (r.latching) begin
               if (!em_cond) begin
                  next_r.em_state = titl_em_idle;
               end
            end else if (bus.button) begin
               // The entering press must end before a hold can count
               next_r.em_state = titl_em_armed;
            end
         end
         titl_em_armed: begin
            if (r.latching) begin
               next_r.hold = '0;
               if (!em_cond) begin
                  next_r.em_state = titl_em_idle;
               end else begin
                  next_r.em_state = titl_em_entered;
               end
            end else if (!bus.button) begin
               if (r.hold == HOLD_W'(HOLD_COUNT - 1)) begin
                  next_r.em_state = titl_em_idle;
                  next_r.hold = '0;
               end else begin
                  next_r.hold = r.hold + HOLD_W'(1);
               end
            end else begin
               next_r.hold = '0;
            end
         end
         default: begin
            next_r.em_state = titl_em_idle;
            next_r.hold = '0;
         end
      endcase
      next_r.em_mode = (next_r.em_state != titl_em_idle);
      next_r.led = (next_r.em_state != titl_em_idle);

      // Pin change notice; only the latest values are kept if busy
      if (r.report_en && (bus.level != r.last_values)) begin
         next_r.notice_pending = 1'b1;
      end
      next_r.last_values = bus.level;
      if (r.notice_pending && !bus.tx_busy && !r.tx_start) begin
         next_r.tx_start = 1'b1;
         next_r.tx_byte = {NOTICE_TAG, bus.level};
         if (!(r.report_en && (bus.level != r.last_values))) begin
            next_r.notice_pending = 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '{
            prdata: 32'h0,
            pready: 1'b0,
            pslverr: 1'b0,
            latching: 1'b0,
            report_en: 1'b0,
            incfg: INCFG_RESET,
            outs: OUT_RESET,
            baud: titl_b19200,
            em_state: titl_em_idle,
            hold: '0,
            led: 1'b0,
            em_mode: 1'b0,
            test: 1'b0,
            report_req: 1'b0,
            report_pending: 1'b0,
            notice_pending: 1'b0,
            tx_start: 1'b0,
            tx_byte: 8'h00,
            values: 4'hF,
            last_values: 4'hF
         };
      end else begin
         r <= next_r;
      end
   end

   assign bus.tx_start = r.tx_start;
   assign bus.tx_byte = r.tx_byte;
   assign bus.baud_sel = r.baud;

   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign out_pins = r.outs;
   assign emergency_led = r.led;
   assign emergency_mode = r.em_mode;
   assign test_mode = r.test;
   assign input_report_req = r.report_req;
   assign input_values = r.values;
   assign serial_tx = bus.txd;
endmodule
`default_nettype wire

/* verification/titl_assertions.sv */
// Concurrent checks on the tracker I/O block ports
`timescale 1ns/10ps
`default_nettype none
module titl_assertions
   import titl_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [3:0] ext_in,
   input wire logic remote_out_valid,
   input wire logic [2:0] remote_out_data,
   input wire logic [2:0] out_pins,
   input wire logic emergency_led,
   input wire logic emergency_mode,
   input wire logic test_mode,
   input wire logic input_report_req,
   input wire logic [3:0] input_values
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_access_wait: assert property (
      psel && !penable ##1 psel && penable |-> !pready ##1 pready)
      else $error("access answer not on second cycle");
   a_pready_single: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_led_mode: assert property (emergency_led == emergency_mode)
      else $error("indicator differs from emergency state");
   a_report_pulse: assert property (
      input_report_req |=> !input_report_req)
      else $error("report request longer than one cycle");
   // Test entry lands on the same edge as the input value change
   a_test_cause: assert property (
      $rose(test_mode) |-> input_values != $past(input_values))
      else $error("test mode entered without input edge");
   a_input_track: assert property (
      $stable(ext_in[3:1]) [*6] |-> input_values[3:1] == ext_in[3:1])
      else $error("input values do not follow the pins");
   a_remote_load: assert property (
      remote_out_valid |=> out_pins == $past(remote_out_data))
      else $error("remote update not applied to outputs");

   c_emergency: cover property ($rose(emergency_mode));
   c_test: cover property ($rose(test_mode));
   c_report: cover property (input_report_req);
   c_refused: cover property (pslverr);
endmodule

bind tracker_io_trigger_logic titl_assertions chk_u (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .ext_in(ext_in),
   .remote_out_valid(remote_out_valid),
   .remote_out_data(remote_out_data), .out_pins(out_pins),
   .emergency_led(emergency_led), .emergency_mode(emergency_mode),
   .test_mode(test_mode), .input_report_req(input_report_req),
   .input_values(input_values)
);
`default_nettype wire

/* verification/titl_partner.sv */
// Switches, button and host terminal around the tracker I/O block
`timescale 1ns/10ps
`default_nettype none
module titl_partner
   import titl_pkg::*;
#(
   parameter int BAUD = BAUD_115200
)
(
   input wire logic pclk,
   input wire logic [3:0] sw_closed,
   input wire logic btn_pressed,
   input wire logic serial_tx,
   output logic [3:0] ext_in,
   output logic button_n,
   output logic [7:0] rx_byte,
   output logic [7:0] rx_count
);
   localparam int BIT_CYC = CLK_HZ / BAUD;
   // Open contacts float high through the pull-ups
   assign ext_in = ~sw_closed;
   assign button_n = ~btn_pressed;
   initial begin
      rx_byte = 8'h00;
      rx_count = 8'h00;
   end
   // No rate detection: host listens at one fixed rate only
   always begin : host_rx
      logic [7:0] b;
      @(negedge serial_tx);
      repeat (BIT_CYC / 2) @(posedge pclk);
      if (serial_tx === 1'b0) begin
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge pclk);
            b[i] = serial_tx;
         end
         repeat (BIT_CYC) @(posedge pclk);
         // Bad stop bit yields a byte the bench never expects
         rx_byte = (serial_tx === 1'b1) ? b : ~b;
         rx_count = rx_count + 8'h01;
      end
   end
endmodule
`default_nettype wire

/* verification/tb.sv */
// Self-checking bench of the tracker discrete I/O block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, x) begin \
   n_checks++; \
   if ((a) !== (x)) begin \
      num_errors++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (x)); \
   end \
end
module tb
   import titl_pkg::*;
;
   localparam int HOLD = 50;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic remote_out_valid = 1'b0;
   logic [2:0] remote_out_data = 3'h0;
   logic [3:0] sw_closed = 4'h0;
   logic btn_pressed = 1'b0;
   logic [31:0] prdata, r, v;
   logic pready, pslverr, e, button_n, serial_tx;
   logic emergency_led, emergency_mode, test_mode, input_report_req;
   logic [2:0] out_pins;
   logic [3:0] ext_in, input_values;
   logic [7:0] rx_byte, rx_count, n;
   logic [3:0] pat [2] = '{4'h8, 4'h0};
   logic [31:0] seed = 32'hE6B4CF48;
   int num_errors = 0;
   int n_checks = 0;
   int n_req = 0;
   int k;

   tracker_io_trigger_logic #(.HOLD_COUNT(HOLD)) dut_u (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_in(ext_in), .button_n(button_n),
      .remote_out_valid(remote_out_valid),
      .remote_out_data(remote_out_data), .out_pins(out_pins),
      .emergency_led(emergency_led), .emergency_mode(emergency_mode),
      .test_mode(test_mode), .input_report_req(input_report_req),
      .input_values(input_values), .serial_tx(serial_tx));
   titl_partner host_u (
      .pclk(pclk), .sw_closed(sw_closed), .btn_pressed(btn_pressed),
      .serial_tx(serial_tx), .ext_in(ext_in), .button_n(button_n),
      .rx_byte(rx_byte), .rx_count(rx_count));

   always #5 pclk = ~pclk;
   always @(posedge pclk)
      if (input_report_req === 1'b1)
         n_req <= n_req + 1;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [7:0] note(input logic [3:0] vals);
      return {NOTICE_TAG, vals};
   endfunction

   // Request stands until the edge that sees pready high; read data
   // is taken at that edge, before its own updates land
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int t;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      t = 0;
      do begin
         @(posedge pclk);
         t++;
      end while (pready !== 1'b1 && t < 20);
      if (t >= 20)
         num_errors++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      `CHK(r, x)
   endtask
   task automatic sw(input logic [3:0] c, input logic b);
      @(posedge pclk);
      sw_closed <= c;
      btn_pressed <= b;
   endtask
   task automatic pause(input int c);
      repeat (c) @(posedge pclk);
      @(negedge pclk);
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge pclk);
      num_errors++;
      give_verdict();
   end

   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      pause(1);
      `CHK(serial_tx, 1'b1)
      `CHK(input_values, 4'hF)
      rd(REG_INCFG, {16'h0, INCFG_RESET});
      rd(REG_CTRL, 32'h0);
      rd(REG_BAUD, {29'h0, titl_b19200});
      rd(REG_STATUS, 32'hF);
      rd(8'h18, 32'h0);
      `CHK(e, 1'b1)
      done("reset");
      for (int i = 0; i < 6; i++) begin
         v = rnd();
         apb(1'b1, REG_OUT, {29'h0, v[2:0]});
         pause(1);
         `CHK(out_pins, v[2:0])
         @(posedge pclk);
         remote_out_valid <= 1'b1;
         remote_out_data <= v[5:3];
         @(posedge pclk);
         remote_out_valid <= 1'b0;
         pause(1);
         `CHK(out_pins, v[5:3])
      end
      rd(REG_OUT, {29'h0, v[5:3]});
      done("outputs");
      sw(4'h2, 1'b0);
      pause(8);
      `CHK(test_mode, 1'b1)
      `CHK(emergency_led, 1'b0)
      rd(REG_STATUS, 32'h2D);
      apb(1'b1, REG_CTRL, 32'h4);
      sw(4'h0, 1'b0);
      pause(8);
      `CHK(test_mode, 1'b0)
      done("test input");
      sw(4'h0, 1'b1);
      pause(4);
      sw(4'h0, 1'b0);
      pause(8);
      `CHK(emergency_led, 1'b1)
      sw(4'h0, 1'b1);
      pause(HOLD - 20);
      sw(4'h0, 1'b0);
      pause(8);
      `CHK(emergency_led, 1'b1)
      sw(4'h0, 1'b1);
      pause(HOLD + 20);
      `CHK(emergency_mode, 1'b0)
      sw(4'h0, 1'b0);
      pause(8);
      `CHK(emergency_led, 1'b0)
      sw(4'h1, 1'b0);
      pause(4);
      sw(4'h0, 1'b0);
      pause(8);
      `CHK(emergency_led, 1'b1)
      sw(4'h0, 1'b1);
      pause(HOLD + 20);
      sw(4'h0, 1'b0);
      pause(8);
      `CHK(emergency_led, 1'b0)
      done("momentary");
      apb(1'b1, REG_CTRL, 32'h1);
      sw(4'h1, 1'b0);
      pause(8);
      `CHK(emergency_led, 1'b1)
      sw(4'h0, 1'b1);
      pause(HOLD + 20);
      `CHK(emergency_led, 1'b1)
      sw(4'h0, 1'b0);
      pause(8);
      `CHK(emergency_led, 1'b0)
      apb(1'b1, REG_CTRL, 32'h0);
      done("latching");
      apb(1'b1, REG_INCFG, {16'h0, INCFG_RESET[15:12], 4'h5,
                            INCFG_RESET[7:0]});
      sw(4'h4, 1'b0);
      pause(8);
      `CHK(emergency_led, 1'b0)
      sw(4'h0, 1'b0);
      pause(8);
      `CHK(emergency_led, 1'b1)
      sw(4'h0, 1'b1);
      pause(HOLD + 20);
      sw(4'h0, 1'b0);
      pause(8);
      `CHK(emergency_led, 1'b0)
      apb(1'b1, REG_INCFG, {16'h0, INCFG_RESET});
      done("configured edge");
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, REG_BAUD, i);
         rd(REG_BAUD, i);
      end
      apb(1'b1, REG_BAUD, 32'h6);
      rd(REG_BAUD, {29'h0, titl_b115200});
      apb(1'b1, REG_CTRL, 32'h2);
      for (int i = 0; i < 2; i++) begin
         n = rx_count;
         sw(pat[i], 1'b0);
         pause(8);
         `CHK(n_req, 1)
         k = 0;
         while (rx_count === n && k < 20000) begin
            @(posedge pclk);
            k++;
         end
         if (k >= 20000)
            num_errors++;
         `CHK(rx_byte, note(~pat[i]))
      end
      rd(REG_EVENT, 32'h1);
      apb(1'b1, REG_EVENT, 32'h1);
      rd(REG_EVENT, 32'h0);
      done("notice");
      give_verdict();
   end
endmodule
`default_nettype wire
